// ### verilog/dac_power_pkg.sv
// constants for the dual dac power and fault control block
package dac_power_pkg;
	localparam int FRAME_BITS = 24;
	localparam int BIT_COUNT_WIDTH = 5;
	// frame field positions
	localparam int RW_BIT = 23;
	localparam int REG_SEL_HI = 21;
	localparam int REG_SEL_LO = 19;
	localparam int CHAN_ADDR_HI = 18;
	localparam int CHAN_ADDR_LO = 16;
	localparam int DATA_HI = 15;
	// register select codes
	localparam logic [2:0] REG_SEL_DAC_DATA = 3'h0;
	localparam logic [2:0] REG_SEL_POWER = 3'h2;
	localparam logic [2:0] REG_SEL_CONTROL = 3'h3;
	localparam logic [2:0] CTRL_ADDR_SETUP = 3'h1;
	// power word bit positions
	localparam int PWR_CHAN_A_ON_BIT = 0;
	localparam int PWR_CHAN_B_ON_BIT = 2;
	localparam int PWR_THERMAL_BIT = 5;
	localparam int PWR_CHAN_A_OC_BIT = 7;
	localparam int PWR_CHAN_B_OC_BIT = 9;
	localparam int PWR_MUST_ZERO_BIT = 10;
	// control word bit positions
	localparam int CTRL_CLAMP_EN_BIT = 2;
	localparam int CTRL_TSD_EN_BIT = 3;
	// reset values
	localparam logic CHAN_ON_RESET = 1'b0;
	localparam logic CLAMP_EN_RESET = 1'b1;
	localparam logic TSD_EN_RESET = 1'b0;
	// power-up settling time
	localparam int CLOCK_MHZ = 100;
	localparam int POWER_UP_TIME_US = 10;
	localparam int POWER_UP_CYCLES = POWER_UP_TIME_US * CLOCK_MHZ;
	localparam int SETTLE_COUNT_WIDTH = 11;
	localparam logic [SETTLE_COUNT_WIDTH-1:0] SETTLE_COUNT_RESET = 11'h000;
	localparam int NUM_CHANNELS = 2;
	localparam int SYNC_STAGES = 3;
	typedef enum {
		POWER_HOLD_CLAMPED,
		POWER_RUNNING
	} power_state_type;
endpackage

// ### verilog/dac_power_fault_control.sv
// power sequencing, overcurrent and thermal handling for a dual serial dac
// Functional notes
// - a frame with register select 010 writes the channel power word.
// - bit 0 of the power word powers channel A; default off.
// - bit 2 of the power word powers channel B; default off.
// - both channels start powered down and switch independently.
// - clamp disabled and overcurrent: channel powers down, its power bit clears.
// - clamp enabled: overcurrent sets flag only, flag clears when fault leaves.
// - bit 7 is a read-only channel A overcurrent flag.
// - bit 9 is a read-only channel B overcurrent flag.
// - bit 5 is a read-only thermal flag; overtemperature powers down both channels.
// - thermal shutdown is off after reset and acts only while enabled.
// - a powered-down channel is disconnected and its pin clamped to ground.
// - outputs stay clamped until supplies stable and a dac data word written.
// - frames are 24 bits, each sampled on the falling serial clock edge.
// - clamp enable defaults to current clamp; clearing selects auto power-down.
`timescale 1ns/10ps
module dac_power_fault_control
	import dac_power_pkg::*;
#(
	parameter int SETTLE_CYCLES = POWER_UP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic serial_clk,
	input wire logic frame_sync_n,
	input wire logic serial_data_in,
	input wire logic chan_a_overcurrent,
	input wire logic chan_b_overcurrent,
	input wire logic over_temperature,
	input wire logic supplies_stable,
	output logic [15:0] channel_power_and_alert_word,
	output logic chan_a_amp_connect,
	output logic chan_b_amp_connect,
	output logic chan_a_ground_clamp,
	output logic chan_b_ground_clamp,
	output logic chan_a_settled,
	output logic chan_b_settled
);

	// link side: serial clock domain
	logic [FRAME_BITS-1:0] shift_word;
	logic [FRAME_BITS-1:0] frame_word;
	logic [BIT_COUNT_WIDTH-1:0] bit_count;
	logic frame_toggle;
	logic [FRAME_BITS-1:0] next_shift_word;
	logic last_bit;
	logic frame_full;

	assign next_shift_word = {shift_word[FRAME_BITS-2:0], serial_data_in};
	assign last_bit = (bit_count == BIT_COUNT_WIDTH'(FRAME_BITS - 1));
	assign frame_full = (bit_count == BIT_COUNT_WIDTH'(FRAME_BITS));

	// the frame's own sync line restarts the count, so no idle serial clock edge is needed
	// counting stops past the last bit, so a long frame is neither taken twice nor toggled again
	always_ff @(negedge serial_clk or posedge frame_sync_n or posedge rst) begin
		if (rst || frame_sync_n) begin
			bit_count <= '0;
		end else if (!frame_full) begin
			bit_count <= bit_count + 1'b1;
		end
	end

	always_ff @(negedge serial_clk or posedge rst) begin
		if (rst) begin
			shift_word <= '0;
		end else if (!frame_sync_n) begin
			shift_word <= next_shift_word;
		end
	end

	// the captured word holds still for a whole frame, far longer than the crossing takes
	always_ff @(negedge serial_clk or posedge rst) begin
		if (rst) begin
			frame_word <= '0;
		end else if (!frame_sync_n && last_bit) begin
			frame_word <= next_shift_word;
		end
	end

	always_ff @(negedge serial_clk or posedge rst) begin
		if (rst) begin
			frame_toggle <= 1'b0;
		end else if (!frame_sync_n && last_bit) begin
			frame_toggle <= ~frame_toggle;
		end
	end

	// core side: synchronisers
	logic [SYNC_STAGES-1:0] toggle_sync;
	logic frame_done;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			toggle_sync <= '0;
		end else begin
			toggle_sync <= {toggle_sync[SYNC_STAGES-2:0], frame_toggle};
		end
	end

	// only stages two and three feed the edge detect; stage one may be metastable
	assign frame_done = toggle_sync[2] ^ toggle_sync[1];

	localparam int NUM_PINS = 4;
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] pin_level;
	// the supplies pin shares the same three-stage filter as the fault pins
	assign pin_raw = {supplies_stable, over_temperature, chan_b_overcurrent, chan_a_overcurrent};

	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_pin_sync
			logic [SYNC_STAGES-1:0] stage;
			logic agree;
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					stage <= '0;
				end else begin
					stage <= {stage[SYNC_STAGES-2:0], pin_raw[p]};
				end
			end
			// a change counts only once the second and third stages agree
			assign agree = (stage[2] == stage[1]);
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					pin_level[p] <= 1'b0;
				end else if (agree) begin
					pin_level[p] <= stage[2];
				end
			end
		end
	endgenerate

	logic [NUM_CHANNELS-1:0] overcurrent;
	logic hot;
	logic supplies_ok;
	// flags read the filtered pin, so a glitch shorter than two cycles is not flagged
	assign overcurrent = pin_level[1:0];
	assign hot = pin_level[2];
	assign supplies_ok = pin_level[3];

	// frame decode; only write frames matter here, read-back lies outside this block
	function automatic logic reg_hit(input logic [FRAME_BITS-1:0] word, input logic [2:0] sel);
		reg_hit = !word[RW_BIT] && (word[REG_SEL_HI:REG_SEL_LO] == sel);
	endfunction

	logic power_write;
	logic control_write;
	logic data_write;
	logic setup_addr;
	assign power_write = frame_done && reg_hit(frame_word, REG_SEL_POWER);
	// only the setup address of the control register carries the enable bits
	assign setup_addr = (frame_word[CHAN_ADDR_HI:CHAN_ADDR_LO] == CTRL_ADDR_SETUP);
	assign control_write = frame_done && reg_hit(frame_word, REG_SEL_CONTROL) && setup_addr;
	assign data_write = frame_done && reg_hit(frame_word, REG_SEL_DAC_DATA);

	// control bits
	logic clamp_en;
	logic tsd_en;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clamp_en <= CLAMP_EN_RESET;
		end else if (control_write) begin
			clamp_en <= frame_word[CTRL_CLAMP_EN_BIT];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tsd_en <= TSD_EN_RESET;
		end else if (control_write) begin
			tsd_en <= frame_word[CTRL_TSD_EN_BIT];
		end
	end

	// thermal and overcurrent shutdown
	logic thermal_trip;
	logic [NUM_CHANNELS-1:0] oc_trip;
	logic [NUM_CHANNELS-1:0] host_on;
	logic [NUM_CHANNELS-1:0] chan_on;
	logic [NUM_CHANNELS-1:0] next_chan_on;
	logic thermal_flag;
	logic next_thermal_flag;
	logic [NUM_CHANNELS-1:0] hw_off;

	assign thermal_trip = tsd_en && hot;
	assign oc_trip = clamp_en ? '0 : overcurrent;
	// channel address and bit 10 are not checked; stray values are simply ignored
	assign host_on = {frame_word[PWR_CHAN_B_ON_BIT], frame_word[PWR_CHAN_A_ON_BIT]};

	genvar c;
	generate
		for (c = 0; c < NUM_CHANNELS; c++) begin : g_chan_on
			assign hw_off[c] = oc_trip[c] || thermal_trip;
			// a hardware shutdown wins over a host write in the same cycle
			assign next_chan_on[c] = hw_off[c] ? 1'b0
				: power_write ? host_on[c]
				: chan_on[c];
		end
	endgenerate

	// the flag stays set until the host next writes the power word and heat is gone
	assign next_thermal_flag = thermal_trip ? 1'b1 : (power_write ? 1'b0 : thermal_flag);

	// power bits reset low so both outputs start clamped
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			chan_on <= {NUM_CHANNELS{CHAN_ON_RESET}};
		end else begin
			chan_on <= next_chan_on;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			thermal_flag <= 1'b0;
		end else begin
			thermal_flag <= next_thermal_flag;
		end
	end

	// power-on output hold
	power_state_type power_state;
	power_state_type next_power_state;
	logic hold_release;
	logic running;

	// one-way: a later supply dip does not clamp again, only reset does
	assign hold_release = supplies_ok && data_write;
	assign running = (power_state == POWER_RUNNING);

	always_comb begin
		next_power_state = power_state;
		case (power_state)
			POWER_HOLD_CLAMPED: begin
				if (hold_release) begin
					next_power_state = POWER_RUNNING;
				end
			end
			POWER_RUNNING: begin
				next_power_state = POWER_RUNNING;
			end
			default: begin
				next_power_state = POWER_HOLD_CLAMPED;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			power_state <= POWER_HOLD_CLAMPED;
		end else begin
			power_state <= next_power_state;
		end
	end

	// output switches and settling
	logic [NUM_CHANNELS-1:0] connect;
	logic [NUM_CHANNELS-1:0] ground_clamp;
	logic [NUM_CHANNELS-1:0] settled;
	logic [NUM_CHANNELS-1:0] next_connect;

	// switches follow next_chan_on, so they move on the same edge as the status word
	assign next_connect = running ? next_chan_on : '0;

	generate
		for (c = 0; c < NUM_CHANNELS; c++) begin : g_settle
			logic [SETTLE_COUNT_WIDTH-1:0] count;
			// the counter saturates, so a channel left on never wraps and drops settled
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					count <= SETTLE_COUNT_RESET;
				end else if (!chan_on[c]) begin
					count <= SETTLE_COUNT_RESET;
				end else if (count != SETTLE_COUNT_WIDTH'(SETTLE_CYCLES)) begin
					count <= count + 1'b1;
				end
			end
			// settled only informs the host; loads are not blocked while it is low
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					settled[c] <= 1'b0;
				end else begin
					settled[c] <= chan_on[c] && (count == SETTLE_COUNT_WIDTH'(SETTLE_CYCLES));
				end
			end
		end
	endgenerate

	generate
		for (c = 0; c < NUM_CHANNELS; c++) begin : g_switch
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					connect[c] <= 1'b0;
				end else begin
					connect[c] <= next_connect[c];
				end
			end

			// the clamp has its own flop, held set through reset, so the pin is never left open
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					ground_clamp[c] <= 1'b1;
				end else begin
					ground_clamp[c] <= ~next_connect[c];
				end
			end
		end
	endgenerate

	assign chan_a_amp_connect = connect[0];
	assign chan_b_amp_connect = connect[1];
	assign chan_a_ground_clamp = ground_clamp[0];
	assign chan_b_ground_clamp = ground_clamp[1];
	assign chan_a_settled = settled[0];
	assign chan_b_settled = settled[1];

	// status word; overcurrent flags follow the live fault, so they clear themselves
	logic [15:0] next_status;
	always_comb begin
		next_status = '0;
		next_status[PWR_CHAN_A_ON_BIT] = next_chan_on[0];
		next_status[PWR_CHAN_B_ON_BIT] = next_chan_on[1];
		next_status[PWR_THERMAL_BIT] = next_thermal_flag;
		next_status[PWR_CHAN_A_OC_BIT] = overcurrent[0];
		next_status[PWR_CHAN_B_OC_BIT] = overcurrent[1];
		next_status[PWR_MUST_ZERO_BIT] = 1'b0;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			channel_power_and_alert_word <= '0;
		end else begin
			channel_power_and_alert_word <= next_status;
		end
	end

endmodule

// ### bench/dac_power_monitor.sv
// assertions on the power and fault control ports
`timescale 1ns/10ps
module dac_power_monitor #(
	parameter int SETTLE_CYCLES = 20
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic chan_a_overcurrent,
	input wire logic chan_b_overcurrent,
	input wire logic [15:0] channel_power_and_alert_word,
	input wire logic chan_a_amp_connect,
	input wire logic chan_b_amp_connect,
	input wire logic chan_a_ground_clamp,
	input wire logic chan_b_ground_clamp,
	input wire logic chan_a_settled
);
	wire logic [15:0] w = channel_power_and_alert_word;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_reset_state_clear: assert property ($past(rst) |-> w == 16'h0000 && !chan_a_amp_connect && !chan_b_amp_connect)
		else $error("outputs not cleared after reset");
	chk_clamp_inverse: assert property (chan_a_ground_clamp != chan_a_amp_connect && chan_b_ground_clamp != chan_b_amp_connect)
		else $error("clamp and amplifier switch disagree");
	chk_off_disconnects: assert property ((!w[0] && !w[2]) [*3] |-> !chan_a_amp_connect && !chan_b_amp_connect)
		else $error("powered-down channel still connected");
	chk_unused_bits_zero: assert property ((w & 16'hFD5A) == 16'h0000)
		else $error("unused status bit set");
	chk_a_oc_flag: assert property (chan_a_overcurrent [*8] |-> w[7])
		else $error("channel A overcurrent flag missing");
	chk_b_oc_flag: assert property (chan_b_overcurrent [*8] |-> w[9])
		else $error("channel B overcurrent flag missing");
	chk_thermal_off: assert property (w[5] [*3] |-> !w[0] && !w[2])
		else $error("channel on during thermal alert");
	chk_settle_time: assert property ($rose(chan_a_settled) |-> $past(w[0], SETTLE_CYCLES - 1))
		else $error("channel A settled too early");
	cover property (w[7] && w[0]);
	cover property (w[5]);
	cover property ($rose(chan_a_settled));
endmodule
bind dac_power_fault_control dac_power_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) dac_power_monitor_i (
	.ref_clk(ref_clk), .rst(rst), .chan_a_overcurrent(chan_a_overcurrent), .chan_b_overcurrent(chan_b_overcurrent),
	.channel_power_and_alert_word(channel_power_and_alert_word), .chan_a_amp_connect(chan_a_amp_connect),
	.chan_b_amp_connect(chan_b_amp_connect), .chan_a_ground_clamp(chan_a_ground_clamp),
	.chan_b_ground_clamp(chan_b_ground_clamp), .chan_a_settled(chan_a_settled));

// ### bench/dac_host_model.sv
// host serial port model: 24-bit frames, clock idles high outside frames
`timescale 1ns/10ps
module dac_host_model (
	output logic serial_clk,
	output logic frame_sync_n,
	output logic serial_data_in
);
	initial begin
		serial_clk = 1'b1;
		frame_sync_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// msb first, data moves after the rising edge so the falling edge sees it settled
	task automatic send(input logic [23:0] f);
		#7 frame_sync_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			serial_data_in = f[i];
			#24 serial_clk = 1'b0;
			#24 serial_clk = 1'b1;
		end
		// released line shows no stale bit
		serial_data_in = ~serial_data_in;
		#24 frame_sync_n = 1'b1;
	endtask
endmodule

// ### bench/dac_power_fault_control_tb.sv
// self-checking bench for the dac power and fault control block
`timescale 1ns/10ps
module dac_power_fault_control_tb;
	import dac_power_pkg::*;
	logic ref_clk, rst, sclk, sync_n, sdi, oc_a, oc_b, hot, sup;
	logic [15:0] word;
	logic a_con, b_con, a_clp, b_clp, a_set, b_set;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	wire logic [15:0] sw = {12'h000, b_con, a_con, b_clp, a_clp};
	dac_power_fault_control #(.SETTLE_CYCLES(20)) dac_power_fault_control_i (.ref_clk(ref_clk), .rst(rst),
		.serial_clk(sclk), .frame_sync_n(sync_n), .serial_data_in(sdi), .chan_a_overcurrent(oc_a),
		.chan_b_overcurrent(oc_b), .over_temperature(hot), .supplies_stable(sup),
		.channel_power_and_alert_word(word), .chan_a_amp_connect(a_con), .chan_b_amp_connect(b_con),
		.chan_a_ground_clamp(a_clp), .chan_b_ground_clamp(b_clp), .chan_a_settled(a_set), .chan_b_settled(b_set));
	dac_host_model dac_host_model_i (.serial_clk(sclk), .frame_sync_n(sync_n), .serial_data_in(sdi));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task summarize;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// run is about 1500 cycles, so this only trips on a hang
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 8000) begin
			n_mismatch++;
			summarize();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// fault pins pass a synchroniser, so allow ten cycles
	task pins(input logic a, input logic b, input logic t);
		@(posedge ref_clk);
		oc_a <= a;
		oc_b <= b;
		hot <= t;
		repeat (10) @(posedge ref_clk);
	endtask
	task send(input logic [23:0] f);
		dac_host_model_i.send(f);
		repeat (8) @(posedge ref_clk);
	endtask
	task t_hold;
		chk(word, 16'h0000);
		chk(sw, 16'h0003);
		send(24'h10_0005);
		chk(word, 16'h0005);
		send(24'h00_1234);
		chk(sw, 16'h0003);
		@(posedge ref_clk) sup <= 1'b1;
		send(24'h00_1234);
		chk(sw, 16'h000C);
	endtask
	task t_bits;
		send(24'h10_0004);
		chk(sw, 16'h0009);
		send(24'h10_FBFB);
		chk(word, 16'h0001);
		chk({14'h0000, b_set, a_set}, 16'h0000);
		repeat (25) @(posedge ref_clk);
		chk({14'h0000, b_set, a_set}, 16'h0001);
		send(24'h90_0004);
		chk(word, 16'h0001);
		send(24'h10_0005);
	endtask
	task t_oc;
		pins(1'b1, 1'b0, 1'b0);
		chk(word, 16'h0085);
		pins(1'b0, 1'b1, 1'b0);
		chk(word, 16'h0205);
		pins(1'b0, 1'b0, 1'b0);
		chk(word, 16'h0005);
	endtask
	task t_auto;
		send(24'h19_0000);
		pins(1'b1, 1'b0, 1'b0);
		chk(word, 16'h0084);
		chk(sw, 16'h0009);
		pins(1'b0, 1'b0, 1'b0);
		chk(word, 16'h0004);
		send(24'h10_0005);
		chk(word, 16'h0005);
	endtask
	task t_heat;
		pins(1'b0, 1'b0, 1'b1);
		chk(word, 16'h0005);
		pins(1'b0, 1'b0, 1'b0);
		send(24'h19_0008);
		pins(1'b0, 1'b0, 1'b1);
		chk(word, 16'h0020);
		pins(1'b0, 1'b0, 1'b0);
		send(24'h10_0005);
		chk(word, 16'h0005);
	endtask
	initial begin
		rst = 1'b1;
		oc_a = 1'b0;
		oc_b = 1'b0;
		hot = 1'b0;
		sup = 1'b0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_hold();
		t_bits();
		t_oc();
		t_auto();
		t_heat();
		summarize();
	end
endmodule
